/* logic/dual_dac_control_registers.sv */
`timescale 1ns/1ps
`default_nettype none
module dual_dac_control_registers #(
  parameter bit LARGE_DEVICE = 1'b1,
  parameter logic [11:0] NOISE_SHIFT_REG_TAPS = 12'h829
) (
  // clock, reset, enable
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic clk_en,
  // peripheral bus slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [dac_ctrl_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // holding register side
  input wire logic [dac_ctrl_pkg::SAMPLE_W-1:0] ch1_held_sample,
  input wire logic ch1_held_write,
  input wire logic [dac_ctrl_pkg::SAMPLE_W-1:0] ch2_held_sample,
  input wire logic ch2_held_write,
  // trigger sources
  input wire logic [dac_ctrl_pkg::TIMER_SRCS-1:0] timer_trigger_out,
  input wire logic trigger3_alt_timer,
  input wire logic trigger3_remap_sel,
  input wire logic ext_line9,
  // output words
  output logic [dac_ctrl_pkg::SAMPLE_W-1:0] ch1_output_word,
  output logic [dac_ctrl_pkg::SAMPLE_W-1:0] ch2_output_word,
  // channel controls
  output logic ch1_on,
  output logic ch2_on,
  output logic ch1_outbuf_off,
  output logic ch2_outbuf_off,
  output logic ch1_dma_req_en,
  output logic ch2_dma_req_en,
  output logic ch1_underrun_irq_en,
  output logic ch2_underrun_irq_en
);

  localparam int unsigned SW = dac_ctrl_pkg::SAMPLE_W;
  localparam int unsigned NCH = dac_ctrl_pkg::CHANNELS;
  localparam int unsigned PL = dac_ctrl_pkg::HW_PIPE_LEN;
  localparam int unsigned AW = dac_ctrl_pkg::ADDR_W;

  typedef struct packed {
    logic [31:0] ctrl;
    logic [NCH-1:0] soft_fire;
    logic [NCH-1:0] clr_pend;
    logic [NCH-1:0][PL-1:0] trig_pipe;
    logic [NCH-1:0][SW-1:0] out_word;
    logic [NCH-1:0][SW-1:0] noise_shift_reg;
    logic [NCH-1:0][SW-1:0] tri_cnt;
    logic [NCH-1:0] tri_down;
    logic [31:0] rdata;
    logic ready;
    logic slverr;
  } state_s;

  state_s st_reg;
  state_s st_next;

  // amplitude code to mask or triangle peak
  function automatic logic [SW-1:0] amp_mask(input logic [3:0] code);
    logic [3:0] sh;
    sh = 4'(dac_ctrl_pkg::MAMP_FULL - code);
    if (code >= dac_ctrl_pkg::MAMP_FULL)
    begin
      return dac_ctrl_pkg::FULL_MASK;
    end
    return dac_ctrl_pkg::FULL_MASK >> sh;
  endfunction

  function automatic dac_ctrl_pkg::wave_mode_e wave_decode(input logic [1:0] code);
    if (code[1])
    begin
      return dac_ctrl_pkg::WM_TRI;
    end
    if (code == 2'(dac_ctrl_pkg::WM_NOISE))
    begin
      return dac_ctrl_pkg::WM_NOISE;
    end
    return dac_ctrl_pkg::WM_NONE;
  endfunction

  // hardware trigger source select; software code is handled apart
  // triggers are sampled as levels: a line held high fires every cycle
  function automatic logic hw_source(input logic [2:0] code);
    logic hit;
    hit = 1'b0;
    case (code)
      dac_ctrl_pkg::TSEL_REMAP:
      begin
        if (LARGE_DEVICE)
        begin
          hit = trigger3_remap_sel ? trigger3_alt_timer : timer_trigger_out[code];
        end
        else
        begin
          hit = trigger3_alt_timer;
        end
      end
      dac_ctrl_pkg::TSEL_EXT9: hit = ext_line9;
      dac_ctrl_pkg::TSEL_SOFT: hit = 1'b0;
      default: hit = timer_trigger_out[code];
    endcase
    return hit;
  endfunction

  // one offset compare shared by decode, write strobes and read select
  function automatic logic reg_hit(input logic [AW-1:0] addr, input logic [AW-1:0] offset);
    return addr == offset;
  endfunction

  logic [NCH-1:0][SW-1:0] held;
  logic [NCH-1:0] held_wr;
  logic acc_phase;
  logic wr_ctrl;
  logic wr_swtrig;
  logic addr_ok;

  assign held[0] = ch1_held_sample;
  assign held[1] = ch2_held_sample;
  assign held_wr[0] = ch1_held_write;
  assign held_wr[1] = ch2_held_write;

  // only aligned word addresses of the two registers respond
  assign addr_ok = (paddr[1:0] == dac_ctrl_pkg::WORD_ALIGN) &&
                   (reg_hit(paddr, dac_ctrl_pkg::CTRL_OFFSET) ||
                    reg_hit(paddr, dac_ctrl_pkg::SWTRIG_OFFSET));
  assign acc_phase = psel && penable && st_reg.ready;
  assign wr_ctrl = acc_phase && pwrite && reg_hit(paddr, dac_ctrl_pkg::CTRL_OFFSET);
  assign wr_swtrig = acc_phase && pwrite && reg_hit(paddr, dac_ctrl_pkg::SWTRIG_OFFSET);

  always_comb
  begin
    int unsigned b;
    logic ten;
    logic [2:0] tsel;
    logic [3:0] mamp;
    dac_ctrl_pkg::wave_mode_e wm;
    logic hw_ev;
    logic sw_ev;
    logic load;
    logic [SW-1:0] wave_val;
    logic [SW-1:0] peak;
    b = 0;
    ten = 1'b0;
    tsel = 3'h0;
    mamp = 4'h0;
    wm = dac_ctrl_pkg::WM_NONE;
    hw_ev = 1'b0;
    sw_ev = 1'b0;
    load = 1'b0;
    wave_val = dac_ctrl_pkg::ZERO_SAMPLE;
    peak = dac_ctrl_pkg::ZERO_SAMPLE;
    st_next = st_reg;

    // bus: setup phase answers in the next cycle with no wait state
    // read data is captured at setup and held through the access cycle
    st_next.ready = 1'b0;
    st_next.slverr = 1'b0;
    if (psel && !penable && !st_reg.ready)
    begin
      st_next.ready = 1'b1;
      st_next.slverr = !addr_ok;
      if (reg_hit(paddr, dac_ctrl_pkg::CTRL_OFFSET))
      begin
        st_next.rdata = st_reg.ctrl;
      end
      else
      begin
        // software trigger register is write-only and reads as zero
        st_next.rdata = dac_ctrl_pkg::READ_ZERO;
      end
    end

    if (wr_ctrl)
    begin
      // reserved bits are kept at zero whatever is written
      st_next.ctrl = pwdata & dac_ctrl_pkg::CTRL_WRITE_MASK;
    end

    for (int c = 0; c < NCH; c++)
    begin
      b = c * dac_ctrl_pkg::CH_STRIDE;
      ten = st_reg.ctrl[b + dac_ctrl_pkg::TEN_BIT];
      tsel = st_reg.ctrl[b + dac_ctrl_pkg::TSEL_LSB +: dac_ctrl_pkg::TSEL_W];
      mamp = st_reg.ctrl[b + dac_ctrl_pkg::MAMP_LSB +: dac_ctrl_pkg::MAMP_W];
      wm = wave_decode(st_reg.ctrl[b + dac_ctrl_pkg::WAVE_LSB +: dac_ctrl_pkg::WAVE_W]);
      peak = amp_mask(mamp);

      // hardware trigger runs through a short delay line
      hw_ev = ten && (tsel != dac_ctrl_pkg::TSEL_SOFT) && hw_source(tsel);
      st_next.trig_pipe[c] = {st_reg.trig_pipe[c][PL-2:0], hw_ev};
      // clr_pend masks the bit while it waits to be cleared
      sw_ev = ten && (tsel == dac_ctrl_pkg::TSEL_SOFT) &&
              st_reg.soft_fire[c] && !st_reg.clr_pend[c];

      if (ten)
      begin
        load = st_reg.trig_pipe[c][PL-1] || sw_ev;
      end
      else
      begin
        load = held_wr[c];
      end

      wave_val = dac_ctrl_pkg::ZERO_SAMPLE;
      if (ten)
      begin
        case (wm)
          dac_ctrl_pkg::WM_NOISE: wave_val = st_reg.noise_shift_reg[c] & peak;
          dac_ctrl_pkg::WM_TRI: wave_val = st_reg.tri_cnt[c];
          default: wave_val = dac_ctrl_pkg::ZERO_SAMPLE;
        endcase
      end

      if (load)
      begin
        // sum wraps at twelve bits; no saturation
        st_next.out_word[c] = held[c] + wave_val;
        if (ten && wm == dac_ctrl_pkg::WM_NOISE)
        begin
          // xnor feedback so the all-zero reset value is a live state
          st_next.noise_shift_reg[c] = {st_reg.noise_shift_reg[c][SW-2:0],
                             ~^(st_reg.noise_shift_reg[c] & NOISE_SHIFT_REG_TAPS)};
        end
        if (ten && wm == dac_ctrl_pkg::WM_TRI)
        begin
          if (!st_reg.tri_down[c])
          begin
            if (st_reg.tri_cnt[c] >= peak)
            begin
              st_next.tri_down[c] = 1'b1;
              st_next.tri_cnt[c] = st_reg.tri_cnt[c] - dac_ctrl_pkg::ONE_SAMPLE;
            end
            else
            begin
              st_next.tri_cnt[c] = st_reg.tri_cnt[c] + dac_ctrl_pkg::ONE_SAMPLE;
            end
          end
          else
          begin
            if (st_reg.tri_cnt[c] == dac_ctrl_pkg::ZERO_SAMPLE)
            begin
              st_next.tri_down[c] = 1'b0;
              st_next.tri_cnt[c] = dac_ctrl_pkg::ONE_SAMPLE;
            end
            else
            begin
              st_next.tri_cnt[c] = st_reg.tri_cnt[c] - dac_ctrl_pkg::ONE_SAMPLE;
            end
          end
        end
      end

      // software trigger bit: cleared one clock after its load
      st_next.clr_pend[c] = sw_ev;
      if (st_reg.clr_pend[c])
      begin
        st_next.soft_fire[c] = 1'b0;
      end
      if (wr_swtrig)
      begin
        // a fresh write wins over the hardware clear
        st_next.soft_fire[c] = pwdata[c];
        st_next.clr_pend[c] = sw_ev && !pwdata[c];
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      st_reg <= '0;
    end
    else if (clk_en)
    begin
      st_reg <= st_next;
    end
  end

  assign prdata = st_reg.rdata;
  assign pready = st_reg.ready;
  assign pslverr = st_reg.slverr;
  assign ch1_output_word = st_reg.out_word[0];
  assign ch2_output_word = st_reg.out_word[1];
  assign ch1_on = st_reg.ctrl[dac_ctrl_pkg::EN_BIT];
  assign ch2_on = st_reg.ctrl[dac_ctrl_pkg::CH_STRIDE + dac_ctrl_pkg::EN_BIT];
  assign ch1_outbuf_off = st_reg.ctrl[dac_ctrl_pkg::BOFF_BIT];
  assign ch2_outbuf_off = st_reg.ctrl[dac_ctrl_pkg::CH_STRIDE + dac_ctrl_pkg::BOFF_BIT];
  assign ch1_dma_req_en = st_reg.ctrl[dac_ctrl_pkg::DMA_BIT];
  assign ch2_dma_req_en = st_reg.ctrl[dac_ctrl_pkg::CH_STRIDE + dac_ctrl_pkg::DMA_BIT];
  assign ch1_underrun_irq_en = st_reg.ctrl[dac_ctrl_pkg::UDR_BIT];
  assign ch2_underrun_irq_en = st_reg.ctrl[dac_ctrl_pkg::CH_STRIDE + dac_ctrl_pkg::UDR_BIT];

endmodule
`default_nettype wire

/* logic/dac_ctrl_pkg.sv */
package dac_ctrl_pkg;
  localparam int unsigned CHANNELS = 2;
  localparam int unsigned SAMPLE_W = 12;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned TIMER_SRCS = 6;

  // register map
  localparam logic [ADDR_W-1:0] CTRL_OFFSET = 8'h00;
  localparam logic [ADDR_W-1:0] SWTRIG_OFFSET = 8'h04;
  localparam logic [1:0] WORD_ALIGN = 2'h0;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] SWTRIG_RESET = 32'h0000_0000;
  localparam logic [31:0] CTRL_WRITE_MASK = 32'h3FFF_3FFF;
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;

  // field layout within one channel half of the control word
  localparam int unsigned CH_STRIDE = 16;
  localparam int unsigned EN_BIT = 0;
  localparam int unsigned BOFF_BIT = 1;
  localparam int unsigned TEN_BIT = 2;
  localparam int unsigned TSEL_LSB = 3;
  localparam int unsigned TSEL_W = 3;
  localparam int unsigned WAVE_LSB = 6;
  localparam int unsigned WAVE_W = 2;
  localparam int unsigned MAMP_LSB = 8;
  localparam int unsigned MAMP_W = 4;
  localparam int unsigned DMA_BIT = 12;
  localparam int unsigned UDR_BIT = 13;

  // trigger source codes
  localparam logic [2:0] TSEL_REMAP = 3'h3;
  localparam logic [2:0] TSEL_EXT9 = 3'h6;
  localparam logic [2:0] TSEL_SOFT = 3'h7;

  // amplitude decode
  localparam logic [3:0] MAMP_FULL = 4'hB;
  localparam logic [SAMPLE_W-1:0] FULL_MASK = 12'hFFF;
  localparam logic [SAMPLE_W-1:0] ZERO_SAMPLE = 12'h000;
  localparam logic [SAMPLE_W-1:0] ONE_SAMPLE = 12'h001;

  typedef enum logic [1:0] {
    WM_NONE = 2'b00,
    WM_NOISE = 2'b01,
    WM_TRI = 2'b10
  } wave_mode_e;

  // latencies in peripheral bus clock cycles
  localparam int unsigned HW_TRIG_CYCLES = 3;
  localparam int unsigned SW_TRIG_CYCLES = 1;
  localparam int unsigned DIRECT_CYCLES = 1;
  localparam int unsigned SWCLR_CYCLES = 1;
  localparam int unsigned HW_PIPE_LEN = HW_TRIG_CYCLES - 1;
endpackage

/* verification/dac_ctrl_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module dac_ctrl_monitor (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic clk_en,
  // bus
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // channel 1 data path
  input wire logic [11:0] ch1_held_sample,
  input wire logic ch1_held_write,
  input wire logic [5:0] timer_trigger_out,
  input wire logic [11:0] ch1_output_word,
  // controls
  input wire logic ch1_on,
  input wire logic ch2_on,
  input wire logic ch1_outbuf_off,
  input wire logic ch2_outbuf_off,
  input wire logic ch1_dma_req_en,
  input wire logic ch2_dma_req_en,
  input wire logic ch1_underrun_irq_en,
  input wire logic ch2_underrun_irq_en
);
  logic [31:0] ctrl_reg;
  logic wr0;
  // shadow of the last control write, so trigger mode is known at the ports
  assign wr0 = clk_en && psel && penable && pready && pwrite && paddr == 8'h00;
  always_ff @(posedge sys_clk)
    if (reset)
      ctrl_reg <= 32'h0;
    else if (wr0)
      ctrl_reg <= pwdata;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  property p_rst;
    $fell(reset) |-> ch1_output_word == 12'h000 && !ch1_on && !ch2_on && !ch2_dma_req_en;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not clear after reset");
  property p_ans;
    clk_en && psel && !penable && !pready |=> pready ##1 !pready;
  endproperty
  a_ans: assert property (p_ans) else $error("bus answer not one cycle");
  property p_err;
    pready && paddr != 8'h00 && paddr != 8'h04 |-> pslverr && prdata == 32'h0;
  endproperty
  a_err: assert property (p_err) else $error("unmapped access not refused");
  property p_rsv;
    pready && !pwrite && paddr == 8'h00 |-> prdata[31:30] == 2'h0 && prdata[15:14] == 2'h0;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved control bits read set");
  property p_sw;
    pready && !pwrite && paddr == 8'h04 |-> prdata == 32'h0 && !pslverr;
  endproperty
  a_sw: assert property (p_sw) else $error("trigger register read not zero");
  property p_on;
    wr0 |=> ch1_on == ctrl_reg[0] && ch2_on == ctrl_reg[16];
  endproperty
  a_on: assert property (p_on) else $error("channel enable wrong");
  property p_boff;
    wr0 |=> ch1_outbuf_off == ctrl_reg[1] && ch2_outbuf_off == ctrl_reg[17];
  endproperty
  a_boff: assert property (p_boff) else $error("buffer disable wrong");
  property p_dma;
    wr0 |=> {ch2_underrun_irq_en, ch2_dma_req_en, ch1_underrun_irq_en, ch1_dma_req_en}
      == {ctrl_reg[29:28], ctrl_reg[13:12]};
  endproperty
  a_dma: assert property (p_dma) else $error("dma controls wrong");
  property p_dir;
    clk_en && ch1_held_write && !ctrl_reg[2] |=> ch1_output_word == $past(ch1_held_sample);
  endproperty
  a_dir: assert property (p_dir) else $error("direct load wrong");
  property p_hw;
    clk_en && ctrl_reg[2] && ctrl_reg[7:3] == 5'h00 && timer_trigger_out[0]
      |-> ##3 ch1_output_word == $past(ch1_held_sample);
  endproperty
  a_hw: assert property (p_hw) else $error("triggered load wrong");
endmodule
bind dual_dac_control_registers dac_ctrl_monitor dac_ctrl_monitor_inst (
  .sys_clk, .reset, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
  .pready, .pslverr, .ch1_held_sample, .ch1_held_write, .timer_trigger_out,
  .ch1_output_word, .ch1_on, .ch2_on, .ch1_outbuf_off, .ch2_outbuf_off,
  .ch1_dma_req_en, .ch2_dma_req_en, .ch1_underrun_irq_en, .ch2_underrun_irq_en
);
`default_nettype wire

/* verification/trig_src.sv */
`timescale 1ns/1ps
`default_nettype none
module trig_src (
  // request from bench
  input wire logic go,
  input wire logic [2:0] code,
  input wire logic remap_sel,
  // trigger lines
  output logic [5:0] timer_trigger_out,
  output logic trigger3_alt_timer,
  output logic ext_line9
);
  // only the requested line pulses, so a wrong source decode loads nothing
  always_comb
  begin
    timer_trigger_out = 6'h00;
    if (go && code < 3'h6)
      timer_trigger_out[code] = !(code == 3'h3 && remap_sel);
    trigger3_alt_timer = go && code == 3'h3 && remap_sel;
    ext_line9 = go && code == 3'h6;
  end
endmodule
`default_nettype wire

/* verification/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic sys_clk = 1'h0;
  logic reset = 1'h1;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [11:0] ch1_held_sample = 12'h000;
  logic [11:0] ch2_held_sample = 12'h000;
  logic ch1_held_write = 1'h0;
  logic ch2_held_write = 1'h0;
  logic clk_en = 1'h1;
  logic go = 1'h0;
  logic [2:0] code = 3'h0;
  logic trigger3_remap_sel = 1'h0;
  logic [5:0] timer_trigger_out;
  logic trigger3_alt_timer;
  logic ext_line9;
  logic [11:0] ch1_output_word;
  logic [11:0] ch2_output_word;
  logic [31:0] seed = 32'h82AB;
  logic [32:0] rd_q[$];
  logic [11:0] tri_exp[6] = '{12'hFFE, 12'hFFF, 12'h000, 12'h001, 12'h000, 12'hFFF};
  int n_mismatch = 0;
  int cmp_count = 0;
  int i;
  always #20 sys_clk = ~sys_clk;
  dual_dac_control_registers dual_dac_control_registers_inst (
    .sys_clk, .reset, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .ch1_held_sample, .ch1_held_write, .ch2_held_sample,
    .ch2_held_write, .timer_trigger_out, .trigger3_alt_timer, .trigger3_remap_sel,
    .ext_line9, .ch1_output_word, .ch2_output_word, .ch1_on(), .ch2_on(),
    .ch1_outbuf_off(), .ch2_outbuf_off(), .ch1_dma_req_en(), .ch2_dma_req_en(),
    .ch1_underrun_irq_en(), .ch2_underrun_irq_en()
  );
  trig_src trig_src_inst (
    .go, .code, .remap_sel(trigger3_remap_sel), .timer_trigger_out,
    .trigger3_alt_timer, .ext_line9
  );
  function automatic logic [31:0] rnd(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input string n, input logic [32:0] e, input logic [32:0] g);
    cmp_count++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  // word access only, held until pready is seen
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [32:0] e);
    @(posedge sys_clk);
    if (!w)
      rd_q.push_back(e);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'h1;
    @(negedge sys_clk);
    while (pready !== 1'h1)
      @(negedge sys_clk);
    @(posedge sys_clk);
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic fire(input logic [2:0] c, input logic [11:0] e);
    @(posedge sys_clk);
    go <= 1'h1;
    code <= c;
    @(posedge sys_clk);
    go <= 1'h0;
    repeat (2) @(posedge sys_clk);
    #1 chk("ch1 word", 33'(e), 33'(ch1_output_word));
  endtask
  task automatic end_sim;
    $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // read data is compared in its answer cycle, away from the edges
  always @(negedge sys_clk)
    if (pready === 1'h1 && pwrite === 1'h0)
      chk("read", rd_q.pop_front(), {pslverr, prdata});
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    n_mismatch++;
    end_sim;
  end
  initial
  begin
    repeat (12) @(posedge sys_clk);
    reset <= 1'h0;
    apb(1'h0, 8'h00, 32'h0, 33'h0);
    apb(1'h0, 8'h04, 32'h0, 33'h0);
    seed = rnd(seed);
    apb(1'h1, 8'h00, seed & 32'h3FFF3FFF, 33'h0);
    apb(1'h0, 8'h00, 32'h0, {1'h0, seed & 32'h3FFF3FFF});
    apb(1'h0, 8'h0C, 32'h0, {1'h1, 32'h0});
    apb(1'h0, 8'h02, 32'h0, {1'h1, 32'h0});
    apb(1'h1, 8'h00, 32'h000000B0, 33'h0);
    seed = rnd(seed);
    @(posedge sys_clk);
    ch1_held_sample <= seed[11:0];
    ch1_held_write <= 1'h1;
    ch2_held_sample <= seed[23:12];
    ch2_held_write <= 1'h1;
    @(posedge sys_clk);
    ch1_held_write <= 1'h0;
    ch2_held_write <= 1'h0;
    #1 chk("direct word", 33'(seed[11:0]), 33'(ch1_output_word));
    chk("ch2 direct word", 33'(seed[23:12]), 33'(ch2_output_word));
    // a held write while frozen must be lost
    @(posedge sys_clk);
    clk_en <= 1'h0;
    ch1_held_sample <= ~seed[11:0];
    ch1_held_write <= 1'h1;
    @(posedge sys_clk);
    clk_en <= 1'h1;
    ch1_held_write <= 1'h0;
    #1 chk("frozen word", 33'(seed[11:0]), 33'(ch1_output_word));
    for (i = 0; i < 14; i++)
    begin
      apb(1'h1, 8'h00, 32'h003C0004 | 32'((i % 7) << 3), 33'h0);
      trigger3_remap_sel <= (i > 6);
      seed = rnd(seed);
      ch1_held_sample <= seed[11:0];
      fire(3'(i % 7), seed[11:0]);
    end
    @(posedge sys_clk);
    ch2_held_sample <= 12'hA5C;
    apb(1'h1, 8'h04, 32'h2, 33'h0);
    @(posedge sys_clk);
    #1 chk("ch2 word", 33'h0A5C, 33'(ch2_output_word));
    // a bit left set would reload the new held value
    @(posedge sys_clk);
    ch2_held_sample <= 12'h5A3;
    repeat (2) @(posedge sys_clk);
    #1 chk("ch2 word after clear", 33'h0A5C, 33'(ch2_output_word));
    @(posedge sys_clk);
    reset <= 1'h1;
    @(posedge sys_clk);
    reset <= 1'h0;
    ch1_held_sample <= 12'hFFE;
    apb(1'h1, 8'h00, 32'h00000074, 33'h0);
    fire(3'h6, 12'hFFE);
    fire(3'h6, 12'hFFF);
    apb(1'h1, 8'h00, 32'h000001B4, 33'h0);
    for (i = 0; i < 6; i++)
      fire(3'h6, tri_exp[i]);
    // noise state is 12'h002 here; code 12 must pass it unmasked
    apb(1'h1, 8'h00, 32'h00000C74, 33'h0);
    fire(3'h6, 12'h000);
    end_sim;
  end
endmodule
`default_nettype wire
